//--- rtl/tsc_scheduler.sv
/*
  Conversion scheduler, power-mode control and over-temperature indicator, Wishbone slave.
  Assumes a 10 MHz clk_i, synchronous reset, asynchronous pins conv_start_i and addr_sel_i,
  and an analog sample temp_code_i that is valid on the system clock when a conversion ends.
*/
// What this block does
// - reset points pointer at temperature, comparator mode, indicator active low, queue one.
// - default limits 80 and 75 degrees let it work as a thermostat alone.
// - shutdown and pin mode clear: convert every 400 us, partial power-down after each conversion.
// - each periodic conversion lasts 40 us; the rest of the period is powered down.
// - temperature read during a conversion aborts it and starts a new one.
// - such a read returns the last completed result, never a partial one.
// - after a restart the next conversion comes 400 us after the restarted one.
// - read between conversions starts one, then the 400 us cadence resumes.
// - shutdown set gives full power-down with no periodic conversions.
// - in full power-down a write runs exactly one conversion, then powers down.
// - registers stay readable in full power-down.
// - the top bit of the second config register selects pin-triggered mode.
// - in pin mode with shutdown clear only the start pin starts conversions.
// - pin high at conversion end: stay powered, convert on the next falling edge.
// - pin low at conversion end: power down automatically.
// - rising edge from power-down starts 4 us power-up; long pulse converts on falling edge.
// - pulse shorter than 4 us: conversion held off until 4 us after the rise.
// - device address low three bits come from pins, 1001000 to 1001111.
// - setting shutdown also clears the indicator.
// - mode bit: 0 comparator with hysteresis, 1 interrupt cleared by a read.
// - polarity bit: 0 active low, 1 active high.
// - fault queue needs 1, 2, 4 or 6 consecutive faults; a good result resets it.
module tsc_scheduler (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic        conv_start_i,
  input  wire logic [2:0]  addr_sel_i,
  input  wire logic [9:0]  temp_code_i,
  output logic             oti_o,
  output logic             oti_oe_o,
  output logic      [6:0]  dev_addr_o,
  output logic             powered_o,
  output logic             converting_o
);
  tsc_pkg::tsc_state_t state_q, state_d;
  logic [2:0]  cs_sync_q;
  logic [2:0]  asel_m_q, asel_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic [4:0]  cfg_q;
  logic        pin_mode_q;
  logic [8:0]  trip_q, hyst_q;
  logic [2:0]  pointer_q;
  logic [9:0]  temp_q;
  logic [11:0] conv_cnt_q, period_cnt_q, pwr_cnt_q;
  logic [2:0]  fcnt_q;
  logic        seek_hi_q, ind_q;
  logic        start;
  logic [31:0] rd_word;

  // pin synchronisers; stage 0 feeds stage 1 only
  always_ff @(posedge clk_i)
  begin
    cs_sync_q <= {cs_sync_q[1:0], conv_start_i};
    asel_m_q  <= addr_sel_i;
    asel_q    <= asel_m_q;
  end
  wire cs_level = cs_sync_q[1];
  wire cs_rise  = cs_sync_q[1] & ~cs_sync_q[2];
  wire cs_fall  = ~cs_sync_q[1] & cs_sync_q[2];

  // bus decode
  wire       bus_req  = wb_cyc_i & wb_stb_i & ~ack_q;
  wire       addr_ok  = (wb_adr_i[7:5] == 3'h0);
  wire [2:0] reg_idx  = wb_adr_i[4:2];
  wire       wr_en    = bus_req & wb_we_i & addr_ok;
  wire       rd_en    = bus_req & ~wb_we_i & addr_ok;
  wire       wr_b0    = wr_en & wb_sel_i[0];
  wire       wr_b1    = wr_en & wb_sel_i[1];
  wire       wr_cfg   = wr_b0 & (reg_idx == tsc_pkg::REG_CONFIG);
  wire       temp_rd  = rd_en & (reg_idx == tsc_pkg::REG_TEMP);

  wire       shutdown   = cfg_q[tsc_pkg::CFG_SHUTDOWN];
  wire       int_mode   = cfg_q[tsc_pkg::CFG_MODE];
  wire       polarity   = cfg_q[tsc_pkg::CFG_POL];
  wire [1:0] fq_sel     = cfg_q[tsc_pkg::CFG_FQ_LO +: 2];
  wire       free_mode  = ~shutdown & ~pin_mode_q;
  // old shutdown value, so the write that sets shutdown does not itself wake the part
  wire       wake_write = wr_en & shutdown;
  wire       restart_rd = temp_rd & free_mode;
  wire       conv_done  = (state_q == tsc_pkg::ST_CONV) && (conv_cnt_q == tsc_pkg::CONV_CYC - 12'h001);
  wire       conv_ok    = conv_done & ~restart_rd;
  wire       period_tick = (period_cnt_q == tsc_pkg::PERIOD_CYC - 12'h001);
  wire       pwr_done   = (state_q == tsc_pkg::ST_PWRUP) && (pwr_cnt_q == tsc_pkg::PWRUP_CYC - 12'h001);
  wire       shut_entry = wr_cfg & wb_dat_i[tsc_pkg::CFG_SHUTDOWN] & ~shutdown;

  // fault queue and limit compare
  wire [2:0] fq_need  = (fq_sel == 2'h0) ? 3'h1 : (fq_sel == 2'h1) ? 3'h2 : (fq_sel == 2'h2) ? 3'h4 : 3'h6;
  wire signed [8:0] t9 = $signed(temp_code_i[9:1]);
  wire       fault_hit = seek_hi_q ? (t9 > $signed(trip_q)) : (t9 < $signed(hyst_q));
  wire [2:0] fcnt_inc  = fcnt_q + 3'h1;
  wire       fire      = conv_ok & fault_hit & (fcnt_inc == fq_need);

  always_comb
  begin
    state_d = state_q;
    start   = 1'b0;
    case (state_q)
      tsc_pkg::ST_PART:
        if (shutdown)
          state_d = tsc_pkg::ST_FULL;
        else if (pin_mode_q)
        begin
          if (cs_rise)
            state_d = tsc_pkg::ST_PWRUP;
        end
        else if (period_tick | restart_rd)
          start = 1'b1;
      tsc_pkg::ST_CONV:
        if (restart_rd)
          start = 1'b1;
        else if (conv_done)
        begin
          if (shutdown)
            state_d = tsc_pkg::ST_FULL;
          else if (pin_mode_q && cs_level)
            state_d = tsc_pkg::ST_READY;
          else
            state_d = tsc_pkg::ST_PART;
        end
      tsc_pkg::ST_FULL:
        if (wake_write)
          start = 1'b1;
        else if (!shutdown)
          state_d = tsc_pkg::ST_PART;
      tsc_pkg::ST_PWRUP:
        if (shutdown)
          state_d = tsc_pkg::ST_FULL;
        else if (pwr_done)
        begin
          if (cs_level)
            state_d = tsc_pkg::ST_READY;
          else
            start = 1'b1;
        end
      tsc_pkg::ST_READY:
        if (shutdown)
          state_d = tsc_pkg::ST_FULL;
        else if (!pin_mode_q)
          state_d = tsc_pkg::ST_PART;
        else if (cs_fall)
          start = 1'b1;
      default:
        state_d = tsc_pkg::ST_PART;
    endcase
    if (start)
      state_d = tsc_pkg::ST_CONV;
  end

  // scheduler and timers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q      <= tsc_pkg::ST_PART;
      conv_cnt_q   <= 12'h000;
      period_cnt_q <= 12'h000;
      pwr_cnt_q    <= 12'h000;
    end
    else
    begin
      state_q      <= state_d;
      conv_cnt_q   <= start ? 12'h000 : conv_cnt_q + 12'h001;
      // every start restarts the period, so cadence follows the latest conversion
      period_cnt_q <= (start | period_tick) ? 12'h000 : period_cnt_q + 12'h001;
      pwr_cnt_q    <= (state_q == tsc_pkg::ST_PWRUP) ? pwr_cnt_q + 12'h001 : 12'h000;
    end
  end

  // result and indicator
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      temp_q    <= 10'h000;
      fcnt_q    <= 3'h0;
      seek_hi_q <= 1'b1;
      ind_q     <= 1'b0;
    end
    else
    begin
      if (conv_ok)
        temp_q <= temp_code_i;
      if (shut_entry)
      begin
        fcnt_q    <= 3'h0;
        seek_hi_q <= 1'b1;
        ind_q     <= 1'b0;
      end
      else
      begin
        if (conv_ok)
          fcnt_q <= (fault_hit & ~fire) ? fcnt_inc : 3'h0;
        if (fire)
        begin
          seek_hi_q <= ~seek_hi_q;
          ind_q     <= int_mode ? 1'b1 : seek_hi_q;
        end
        else if (int_mode & rd_en)
          ind_q <= 1'b0;
      end
    end
  end

  // registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_q      <= tsc_pkg::CONFIG_RST;
      pin_mode_q <= tsc_pkg::PIN_MODE_RST;
      trip_q     <= tsc_pkg::TRIP_RST;
      hyst_q     <= tsc_pkg::HYST_RST;
      pointer_q  <= tsc_pkg::POINTER_RST;
    end
    else
    begin
      if (wr_cfg)
        cfg_q <= wb_dat_i[4:0];
      if (wr_b0 && reg_idx == tsc_pkg::REG_SECOND_CONFIG_REGISTER)
        pin_mode_q <= wb_dat_i[tsc_pkg::CFG2_PIN];
      if (wr_b0 && reg_idx == tsc_pkg::REG_TRIP)
        trip_q[7:0] <= wb_dat_i[7:0];
      if (wr_b1 && reg_idx == tsc_pkg::REG_TRIP)
        trip_q[8] <= wb_dat_i[8];
      if (wr_b0 && reg_idx == tsc_pkg::REG_HYST)
        hyst_q[7:0] <= wb_dat_i[7:0];
      if (wr_b1 && reg_idx == tsc_pkg::REG_HYST)
        hyst_q[8] <= wb_dat_i[8];
      if (wr_b0 && reg_idx == tsc_pkg::REG_POINTER)
        pointer_q <= wb_dat_i[2:0];
    end
  end

  // read mux; reads are served in every power state, and the status register reports state_q
  always_comb
  begin
    case (reg_idx)
      tsc_pkg::REG_TEMP:    rd_word = {22'h0, temp_q};
      tsc_pkg::REG_CONFIG:  rd_word = {27'h0, cfg_q};
      tsc_pkg::REG_HYST:    rd_word = {23'h0, hyst_q};
      tsc_pkg::REG_TRIP:    rd_word = {23'h0, trip_q};
      tsc_pkg::REG_SECOND_CONFIG_REGISTER: rd_word = {24'h0, pin_mode_q, 7'h0};
      tsc_pkg::REG_STATUS:  rd_word = {26'h0, ind_q, seek_hi_q, 1'b0, state_q};
      tsc_pkg::REG_POINTER: rd_word = {29'h0, pointer_q};
      tsc_pkg::REG_DEVADDR: rd_word = {25'h0, tsc_pkg::BUS_ADDR_HI, asel_q};
      default:              rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end
    else
    begin
      ack_q <= bus_req;
      if (bus_req & ~wb_we_i)
        dat_q <= addr_ok ? rd_word : 32'h0;
    end
  end

  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = dat_q;
  assign dev_addr_o   = {tsc_pkg::BUS_ADDR_HI, asel_q};
  // open drain: only ever pulls low, enable marks the low level
  assign oti_o        = 1'b0;
  assign oti_oe_o     = ind_q ^ polarity;
  assign powered_o    = (state_q != tsc_pkg::ST_PART) && (state_q != tsc_pkg::ST_FULL);
  assign converting_o = (state_q == tsc_pkg::ST_CONV);

  // helper for the length check: counts converting cycles apart from conv_cnt_q
  logic [11:0] run_len_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !converting_o || restart_rd)
      run_len_q <= 12'h000;
    else
      run_len_q <= run_len_q + 12'h001;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  reset_defaults_a: assert property ($past(rst_i) |-> cfg_q == 5'h00 && pointer_q == 3'h0 && !oti_oe_o)
    else $error("reset defaults wrong");
  limit_defaults_a: assert property ($past(rst_i) |-> trip_q == 9'h0a0 && hyst_q == 9'h096)
    else $error("limit defaults wrong");
  period_start_a: assert property (free_mode && state_q == tsc_pkg::ST_PART && period_tick |=> converting_o)
    else $error("periodic conversion missed");
  conv_length_a: assert property ($fell(converting_o) |-> $past(run_len_q) == tsc_pkg::CONV_CYC - 12'h001)
    else $error("conversion length wrong");
  idle_read_a: assert property (restart_rd && state_q == tsc_pkg::ST_PART |=> converting_o && period_cnt_q == 12'h000)
    else $error("read between conversions did not start one");
  pin_mode_a: assert property (wr_b0 && reg_idx == tsc_pkg::REG_SECOND_CONFIG_REGISTER |=> pin_mode_q == $past(wb_dat_i[tsc_pkg::CFG2_PIN]))
    else $error("pin mode bit not written");
  full_read_a: assert property (state_q == tsc_pkg::ST_FULL && rd_en |=> wb_ack_o && wb_dat_o == $past(rd_word))
    else $error("read refused in full power-down");
  read_abort_a: assert property (restart_rd && converting_o |=> converting_o && conv_cnt_q == 12'h000 && period_cnt_q == 12'h000)
    else $error("read did not restart conversion");
  result_hold_a: assert property (restart_rd |=> $stable(temp_q))
    else $error("partial result stored");
  full_down_a: assert property (state_q == tsc_pkg::ST_FULL && shutdown && !wake_write |=> !converting_o)
    else $error("conversion in full power-down");
  wake_once_a: assert property (state_q == tsc_pkg::ST_FULL && wake_write |=> converting_o)
    else $error("write did not wake");
  pin_only_a: assert property (pin_mode_q && !shutdown && state_q == tsc_pkg::ST_PART && !cs_rise |=> !converting_o)
    else $error("conversion without pin");
  pin_high_ready_a: assert property (pin_mode_q && !shutdown && conv_ok && cs_level |=> state_q == tsc_pkg::ST_READY)
    else $error("powered down with pin high");
  pin_low_down_a: assert property (pin_mode_q && !shutdown && conv_ok && !cs_level |=> state_q == tsc_pkg::ST_PART)
    else $error("no power-down with pin low");
  pwrup_hold_a: assert property (state_q == tsc_pkg::ST_PWRUP && pwr_cnt_q < tsc_pkg::PWRUP_CYC - 12'h001 |=> !converting_o)
    else $error("conversion before power-up time");
  shut_clear_a: assert property (shut_entry |=> !ind_q)
    else $error("indicator not cleared by shutdown");

  abort_c: cover property (restart_rd && converting_o);
  wake_c: cover property (state_q == tsc_pkg::ST_FULL && wake_write);
  pin_short_c: cover property (state_q == tsc_pkg::ST_PWRUP && cs_fall ##[1:40] converting_o);
  fire_c: cover property (fire && int_mode);
  period_c: cover property (free_mode && period_tick && state_q == tsc_pkg::ST_PART);
endmodule // tsc_scheduler

//--- rtl/tsc_pkg.sv
/*
  Constants, register map and state codes for the temperature conversion scheduler.
  Assumes a 10 MHz system clock; all times are turned into cycle counts here.
*/
package tsc_pkg;
  localparam int CLK_PERIOD_NS   = 100;
  localparam int CONV_TIME_NS    = 40000;
  localparam int PERIOD_TIME_NS  = 400000;
  localparam int PWRUP_TIME_NS   = 4000;
  localparam logic [11:0] CONV_CYC   = 12'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] PERIOD_CYC = 12'((PERIOD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] PWRUP_CYC  = 12'((PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // register indexes; byte address is four times the index
  localparam logic [2:0] REG_TEMP    = 3'h0;
  localparam logic [2:0] REG_CONFIG  = 3'h1;
  localparam logic [2:0] REG_HYST    = 3'h2;
  localparam logic [2:0] REG_TRIP    = 3'h3;
  localparam logic [2:0] REG_SECOND_CONFIG_REGISTER = 3'h4;
  localparam logic [2:0] REG_STATUS  = 3'h5;
  localparam logic [2:0] REG_POINTER = 3'h6;
  localparam logic [2:0] REG_DEVADDR = 3'h7;

  // config field positions
  localparam int CFG_SHUTDOWN = 0;
  localparam int CFG_MODE     = 1;
  localparam int CFG_POL      = 2;
  localparam int CFG_FQ_LO    = 3;
  localparam int CFG2_PIN     = 7;

  // values after reset
  localparam logic [4:0] CONFIG_RST  = 5'h00;
  localparam logic       PIN_MODE_RST = 1'b0;
  localparam logic [8:0] TRIP_RST    = 9'h0a0;
  localparam logic [8:0] HYST_RST    = 9'h096;
  localparam logic [2:0] POINTER_RST = 3'h0;
  localparam logic [3:0] BUS_ADDR_HI = 4'h9;

  typedef enum logic [2:0] {
    ST_PART  = 3'b000,
    ST_CONV  = 3'b001,
    ST_FULL  = 3'b010,
    ST_PWRUP = 3'b011,
    ST_READY = 3'b100
  } tsc_state_t;
endpackage

//--- sim/tsc_far_end.sv
/*
  Far-end model: drives the conversion start pin and the sensed temperature code.
  Assumes the bench calls its tasks from one process; pins move only after clk_i rises.
*/
module tsc_far_end (
  input  wire logic       clk_i,
  output logic            conv_start_o,
  output logic      [9:0] temp_code_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    conv_start_o = 1'b0;
    temp_code_o  = 10'h000;
  end

  // callers never move the pin while a bus transfer is open
  task automatic level(input logic v);
    @(posedge clk_i);
    conv_start_o <= v;
  endtask

  // callers wait for the conversion end before the next pulse
  task automatic pulse(input int hi);
    level(1'b1);
    repeat (hi) @(posedge clk_i);
    conv_start_o <= 1'b0;
  endtask

  task automatic set_temp(input logic [9:0] v);
    @(posedge clk_i);
    temp_code_o <= v;
  endtask
endmodule // tsc_far_end

//--- sim/tb.sv
/*
  Self-checking bench for the conversion scheduler: Wishbone register access, free-running
  cadence, read aborts, shutdown, pin-triggered mode and the indicator.
  Assumes a 10 MHz clock and the far-end model driving the start pin and temperature.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic [7:0]  wb_adr   = 8'h00;
  logic [31:0] wb_wdat  = 32'h0;
  logic        wb_we    = 1'b0;
  logic        wb_cyc   = 1'b0;
  logic        wb_stb   = 1'b0;
  logic [3:0]  wb_sel   = 4'h0;
  logic [2:0]  addr_sel = 3'h5;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        over_temp_indicator;
  logic        oti_oe;
  logic        powered;
  logic        converting;
  logic [6:0]  dev_addr;
  wire         conv_start;
  wire  [9:0]  temp_code;
  // pull-up on the open-drain indicator
  wire         oti_pin  = !oti_oe;
  int          err_count = 0;
  int          total_checks = 0;
  int          n;
  int          m;
  logic [31:0] d;
  logic [2:0]  sel_tab[3] = '{3'h0, 3'h7, 3'h5};
  int          fq_tab[4] = '{1, 2, 4, 6};

  always #50 clk_i = ~clk_i;

  tsc_scheduler DUT (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .wb_adr_i     (wb_adr),
    .wb_dat_i     (wb_wdat),
    .wb_dat_o     (wb_rdat),
    .wb_sel_i     (wb_sel),
    .wb_we_i      (wb_we),
    .wb_cyc_i     (wb_cyc),
    .wb_stb_i     (wb_stb),
    .wb_ack_o     (wb_ack),
    .conv_start_i (conv_start),
    .addr_sel_i   (addr_sel),
    .temp_code_i  (temp_code),
    .oti_o        (over_temp_indicator),
    .oti_oe_o     (oti_oe),
    .dev_addr_o   (dev_addr),
    .powered_o    (powered),
    .converting_o (converting)
  );

  tsc_far_end far (
    .clk_i        (clk_i),
    .conv_start_o (conv_start),
    .temp_code_o  (temp_code)
  );

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic timeout(input string nm);
    err_count++;
    $display("mismatch %s expected done seen timeout", nm);
    test_done();
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_rng(input string nm, input int lo, input int hi, input int g);
    total_checks++;
    if (g < lo || g > hi)
    begin
      err_count++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // request held until ack is sampled high, released at that same edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s,
                    output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_sel  <= s;
    wb_adr  <= a;
    wb_wdat <= wd;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack !== 1'b1 && k < 20);
    if (wb_ack !== 1'b1)
      timeout("bus ack");
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    wb(1'b1, a, v, 4'hf, d);
  endtask

  task automatic wr_lane(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    wb(1'b1, a, v, s, d);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf, d);
    check(nm, e, d);
  endtask

  task automatic wait_conv(input logic lvl, output int c);
    c = 0;
    while (converting !== lvl && c < 6000)
    begin
      @(posedge clk_i);
      c++;
    end
    if (converting !== lvl)
      timeout("conversion wait");
  endtask

  // a conversion already running when counting starts is counted once
  task automatic count_conv(input int len, output int c);
    logic p;
    c = 0;
    p = 1'b0;
    repeat (len)
    begin
      @(posedge clk_i);
      if (converting === 1'b1 && p !== 1'b1)
        c++;
      p = converting;
    end
  endtask

  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("config", 8'h04, 32'h0);
    rd_chk("pointer", 8'h18, 32'h0);
    rd_chk("hysteresis", 8'h08, 32'h96);
    rd_chk("trip", 8'h0c, 32'ha0);
    check("indicator idle", 32'h1, oti_pin);
    check("indicator data", 32'h0, over_temp_indicator);
    wr(8'h24, 32'h1f);
    rd_chk("unmapped", 8'h20, 32'h0);
    rd_chk("config kept", 8'h04, 32'h0);
    foreach (sel_tab[i])
    begin
      addr_sel <= sel_tab[i];
      repeat (6) @(posedge clk_i);
      check("bus address", {25'h0, 4'h9, sel_tab[i]}, {25'h0, dev_addr});
      rd_chk("bus address reg", 8'h1c, {25'h0, 4'h9, sel_tab[i]});
    end
    far.set_temp(10'h150);
    wait_conv(1'b1, n);
    wait_conv(1'b0, n);
    check_rng("conversion length", 399, 401, n);
    repeat (2) @(posedge clk_i);
    check("partial power-down", 32'h0, powered);
    check("hot indicator", 32'h0, oti_pin);
    wait_conv(1'b1, m);
    check_rng("period", 3999, 4001, n + m + 2);
    far.set_temp(10'h100);
    repeat (50) @(posedge clk_i);
    rd_chk("temp during conversion", 8'h00, 32'h150);
    wait_conv(1'b0, n);
    check_rng("restarted length", 397, 401, n);
    repeat (2) @(posedge clk_i);
    check("cool indicator", 32'h1, oti_pin);
    wait_conv(1'b1, m);
    check_rng("after restart", 3997, 4001, n + m + 2);
    wait_conv(1'b0, n);
    repeat (100) @(posedge clk_i);
    // a temperature read between conversions starts a new one at once
    rd_chk("temp between", 8'h00, 32'h100);
    wait_conv(1'b1, n);
    check_rng("read start", 0, 2, n);
    wait_conv(1'b0, n);
    wait_conv(1'b1, m);
    check_rng("cadence resumes", 3997, 4001, n + m);
    far.set_temp(10'h150);
    wait_conv(1'b0, n);
    repeat (2) @(posedge clk_i);
    check("hot again", 32'h0, oti_pin);
    wr(8'h04, 32'h1);
    check("shutdown clears", 32'h1, oti_pin);
    count_conv(5000, n);
    check("no periodic", 32'h0, n);
    check("full power-down", 32'h0, powered);
    far.set_temp(10'h0c8);
    wr(8'h08, 32'h96);
    count_conv(1000, n);
    check("one shot", 32'h1, n);
    rd_chk("temp in shutdown", 8'h00, 32'h0c8);
    wr(8'h10, 32'h80);
    repeat (500) @(posedge clk_i);
    wr(8'h04, 32'h0);
    repeat (500) @(posedge clk_i);
    count_conv(4500, n);
    check("pin mode idle", 32'h0, n);
    rd_chk("second_config_register", 8'h10, 32'h80);
    check("pin low powers down", 32'h0, powered);
    fork
      far.pulse(10);
      wait_conv(1'b1, n);
    join
    check_rng("short pulse hold-off", 41, 47, n);
    wait_conv(1'b0, n);
    repeat (2) @(posedge clk_i);
    check("auto power-down", 32'h0, powered);
    fork
      far.pulse(100);
      wait_conv(1'b1, n);
    join
    check_rng("long pulse start", 101, 106, n);
    wait_conv(1'b0, n);
    far.level(1'b1);
    repeat (100) @(posedge clk_i);
    check("powered up", 32'h1, powered);
    fork
      far.level(1'b0);
      wait_conv(1'b1, n);
    join
    check_rng("falling start", 1, 5, n);
    far.level(1'b1);
    wait_conv(1'b0, n);
    count_conv(300, n);
    check("held ready", 32'h0, n);
    check("stays powered", 32'h1, powered);
    fork
      far.level(1'b0);
      wait_conv(1'b1, n);
    join
    check_rng("falling start again", 1, 5, n);
    wait_conv(1'b0, n);
    for (int k = 0; k < 4; k++)
    begin
      far.set_temp(10'h100);
      wr(8'h04, 32'h1);
      wr(8'h04, {27'h0, k[1:0], 3'h6});
      repeat (600) @(posedge clk_i);
      far.set_temp(10'h150);
      for (int i = 0; i < fq_tab[k]; i++)
      begin
        check("queue not full", 32'h0, oti_pin);
        far.pulse(10);
        wait_conv(1'b1, n);
        wait_conv(1'b0, n);
        repeat (2) @(posedge clk_i);
      end
      check("queue full", 32'h1, oti_pin);
      rd_chk("config mode", 8'h04, {27'h0, k[1:0], 3'h6});
      check("read clears", 32'h0, oti_pin);
    end
    // limits are 9 bits split over lanes 0 and 1, each written on its own
    wr_lane(8'h0c, 32'h155, 4'h1);
    rd_chk("trip low lane", 8'h0c, 32'h055);
    wr_lane(8'h0c, 32'h1aa, 4'h2);
    rd_chk("trip high lane", 8'h0c, 32'h155);
    test_done();
  end

  initial
  begin
    repeat (90000) @(posedge clk_i);
    timeout("run");
  end
endmodule // tb
